// >>> rtl/cttd_pkg.sv
package cttd_pkg;
	// Measurement widths
	localparam int CNT_W = 12;
	localparam int REF_FRAC_W = 4;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
	// Calibration length in bursts
	localparam int CAL_BURSTS = 32;
	localparam logic [5:0] CAL_BURSTS_W6 = 6'h20;
	// Clock rate and freeze timeouts
	localparam longint CLK_HZ = 25000000;
	localparam longint HOLD_SHORT_S = 15;
	localparam longint HOLD_LONG_S = 45;
	localparam longint HOLD_SHORT_CYC = HOLD_SHORT_S * CLK_HZ;
	localparam longint HOLD_LONG_CYC = HOLD_LONG_S * CLK_HZ;
	// Freeze timeout codes
	localparam logic [1:0] HOLD_15S = 2'h0;
	localparam logic [1:0] HOLD_45S = 2'h1;
	localparam logic [1:0] HOLD_RSVD = 2'h2;
	localparam logic [1:0] HOLD_INF = 2'h3;
	// Threshold codes
	localparam logic [1:0] THR_STD_PROX = 2'h0;
	localparam logic [1:0] THR_STD_TOUCH = 2'h1;
	localparam logic [1:0] THR_SENS_PROX = 2'h2;
	localparam logic [1:0] THR_SENS_TOUCH = 2'h3;
	// Power modes
	localparam logic [1:0] PWR_NORMAL = 2'h1;
	// Sequencer states
	typedef enum logic [1:0] {
		CTTD_IDLE,
		CTTD_CHARGE,
		CTTD_TRANSFER,
		CTTD_DONE
	} cttd_state_t;
endpackage

// >>> rtl/cttd_top.sv
// Contract
// R1 - Repeat charge/transfer until trip level reached
// R2 - Transfer pulse count is the signal
// R3 - Reference from 32 bursts after power-up
// R4 - Normal timing during calibration
// R5 - Configured low-power timing after calibration
// R6 - Detect when drop reaches threshold
// R7 - Two relative, two absolute thresholds
// R8 - Debounce the comparison result
// R9 - Unity-gain first-order IIR reference
// R10 - Slow changes tracked, fast changes detected
// R11 - Filter active below threshold
// R12 - Freeze reference during detection
// R13 - Resume filtering when detection ends
// R14 - Timeout re-enables filter during detection
// R15 - Two-bit timeout select, 11 infinite
// R16 - Consecutive samples to enter and exit
// R17 - Threshold code mapping
// R18 - Pulse counter saturates
module cttd_top #(
	parameter longint HOLD_SHORT = cttd_pkg::HOLD_SHORT_CYC,
	parameter longint HOLD_LONG = cttd_pkg::HOLD_LONG_CYC,
	parameter int SAMPLE_DIV = 250000,
	parameter int LP_SAMPLE_DIV = 2500000,
	parameter int PHASE_CYC = 50,
	parameter int IIR_SHIFT = 6,
	parameter logic [cttd_pkg::CNT_W-1:0] THR_TOUCH_DIV = 12'h010,
	parameter logic [cttd_pkg::CNT_W-1:0] THR_STOUCH_DIV = 12'h020,
	parameter logic [cttd_pkg::CNT_W-1:0] THR_PROX = 12'h008,
	parameter logic [cttd_pkg::CNT_W-1:0] THR_SPROX = 12'h004,
	parameter logic [3:0] ENTRY_DEB = 4'h4,
	parameter logic [3:0] EXIT_DEB = 4'h4
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset,
	// Configuration straps
	input  wire logic [1:0]                 power_mode,
	input  wire logic [1:0]                 detect_threshold_sel,
	input  wire logic [1:0]                 ref_hold_sel,
	// Analog front end
	input  wire logic                       burst_trip_level,
	output logic                            charge_en,
	output logic                            transfer_en,
	output logic                            discharge_en,
	// Results
	output logic                            detect,
	output logic                            cal_done,
	output logic [cttd_pkg::CNT_W-1:0]      signal_count,
	output logic [cttd_pkg::CNT_W-1:0]      reference
);
	import cttd_pkg::*;

	// Refuse settings that the filter, the burst timing or the hold timeout cannot serve
	if (IIR_SHIFT < 1 || IIR_SHIFT > REF_FRAC_W + 8) begin : g_bad_shift
		$error("IIR_SHIFT out of range");
	end
	if (PHASE_CYC < 1 || SAMPLE_DIV < 4 * PHASE_CYC) begin : g_bad_timing
		$error("sample timing too short");
	end
	if (HOLD_SHORT < 1 || HOLD_LONG < 1) begin : g_bad_hold
		$error("hold timeout must be positive");
	end

	localparam int RW = CNT_W + REF_FRAC_W;

	cttd_state_t state_r;
	logic        trip_s1_r, trip_s2_r;
	logic [31:0] phase_cnt_r, sample_cnt_r;
	logic [CNT_W-1:0] pulse_cnt_r;
	logic        burst_done_r;
	logic [5:0]  cal_cnt_r;
	logic [CNT_W+5:0] cal_sum_r;
	logic [RW-1:0] ref_acc_r;
	logic [3:0]  deb_cnt_r;
	logic [39:0] hold_cnt_r;
	logic        hold_expired;
	logic [CNT_W-1:0] thr;
	logic        below;
	logic [5:0]  strap_s1_r, strap_s2_r;
	logic [1:0]  pwr_mode_s, thr_sel_s, hold_sel_s;
	logic [CNT_W+5:0] cal_sum_nxt;

	// Threshold decode: touch relative to reference, proximity absolute
	function automatic logic [CNT_W-1:0] thr_of(
		input logic [1:0] sel,
		input logic [CNT_W-1:0] refv
	);
		unique case (sel)
			THR_STD_PROX:   thr_of = THR_PROX; // R7 R17
			THR_STD_TOUCH:  thr_of = refv / THR_TOUCH_DIV; // R7 R17
			THR_SENS_PROX:  thr_of = THR_SPROX; // R7 R17
			THR_SENS_TOUCH: thr_of = refv / THR_STOUCH_DIV; // R7 R17
		endcase
	endfunction

	// Trip comparator is asynchronous to clk
	always_ff @(posedge clk) begin
		trip_s1_r <= burst_trip_level;
		trip_s2_r <= trip_s1_r;
	end

	// Straps are pins too; quasi-static, so bits settling apart is harmless
	always_ff @(posedge clk) begin
		strap_s1_r <= {power_mode, detect_threshold_sel, ref_hold_sel};
		strap_s2_r <= strap_s1_r;
	end
	assign {pwr_mode_s, thr_sel_s, hold_sel_s} = strap_s2_r;

	// Free-running sample period, so burst length never stretches it;
	// a burst longer than the period simply skips the next slot
	always_ff @(posedge clk) begin
		if (reset)
			sample_cnt_r <= 32'h0;
		else if (sample_cnt_r <= 32'h1)
			sample_cnt_r <= (!cal_done || pwr_mode_s == PWR_NORMAL) ?
				32'(SAMPLE_DIV) : 32'(LP_SAMPLE_DIV); // R4 R5
		else
			sample_cnt_r <= sample_cnt_r - 32'h1;
	end

	// Burst sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r      <= CTTD_IDLE;
			phase_cnt_r  <= 32'h0;
			pulse_cnt_r  <= '0;
			burst_done_r <= 1'b0;
			charge_en    <= 1'b0;
			transfer_en  <= 1'b0;
			discharge_en <= 1'b1;
		end else begin
			burst_done_r <= 1'b0;
			unique case (state_r)
				CTTD_IDLE: if (sample_cnt_r == 32'h1) begin
					state_r      <= CTTD_CHARGE;
					pulse_cnt_r  <= '0;
					discharge_en <= 1'b0;
					charge_en    <= 1'b1;
					phase_cnt_r  <= 32'(PHASE_CYC);
				end
				CTTD_CHARGE: if (phase_cnt_r == 32'h1) begin
					state_r     <= CTTD_TRANSFER;
					charge_en   <= 1'b0;
					transfer_en <= 1'b1;
					phase_cnt_r <= 32'(PHASE_CYC);
				end else
					phase_cnt_r <= phase_cnt_r - 32'h1;
				CTTD_TRANSFER: if (phase_cnt_r == 32'h1) begin
					transfer_en <= 1'b0;
					if (pulse_cnt_r != CNT_MAX)
						pulse_cnt_r <= pulse_cnt_r + 1'b1; // R2 R18
					if (trip_s2_r) begin
						state_r <= CTTD_DONE; // R1
					end else begin
						state_r     <= CTTD_CHARGE; // R1
						charge_en   <= 1'b1;
						phase_cnt_r <= 32'(PHASE_CYC);
					end
				end else
					phase_cnt_r <= phase_cnt_r - 32'h1;
				CTTD_DONE: begin
					state_r      <= CTTD_IDLE;
					burst_done_r <= 1'b1;
					discharge_en <= 1'b1;
				end
			endcase
		end
	end

	// Signal output
	always_ff @(posedge clk) begin
		if (reset)
			signal_count <= '0;
		else if (burst_done_r)
			signal_count <= pulse_cnt_r; // R2
	end

	// Fresh burst count against reference minus threshold; using the
	// registered copy would judge every burst one sample late
	always_comb begin
		thr   = thr_of(thr_sel_s, reference);
		below = (reference >= pulse_cnt_r) &&
			((reference - pulse_cnt_r) >= thr); // R6
	end

	// Running calibration sum including the burst just finished
	assign cal_sum_nxt = cal_sum_r + {6'h0, pulse_cnt_r}; // R3

	// Calibration and IIR reference; frozen on detect until timeout
	always_ff @(posedge clk) begin
		if (reset) begin
			cal_cnt_r <= 6'h0;
			cal_sum_r <= '0;
			cal_done  <= 1'b0;
			ref_acc_r <= '0;
			reference <= '0;
		end else if (burst_done_r) begin
			if (!cal_done) begin
				cal_sum_r <= cal_sum_nxt; // R3
				cal_cnt_r <= cal_cnt_r + 6'h1;
				if (cal_cnt_r == CAL_BURSTS_W6 - 6'h1) begin
					cal_done  <= 1'b1; // R3
					ref_acc_r <= {cal_sum_nxt[CNT_W+4:5],
						{REF_FRAC_W{1'b0}}};
					reference <= cal_sum_nxt[CNT_W+4:5];
				end
			end else if (!detect || hold_expired) begin
				// Slow drift absorbed, fast steps outrun it
				ref_acc_r <= ref_acc_r -
					(ref_acc_r >>> IIR_SHIFT) +
					(RW'({pulse_cnt_r, {REF_FRAC_W{1'b0}}}) >>
					IIR_SHIFT); // R9 R10 R11 R13 R14
				reference <= ref_acc_r[RW-1:REF_FRAC_W];
			end // R12
		end
	end

	// Freeze timeout counter; reserved code treated as infinite
	always_ff @(posedge clk) begin
		if (reset || !detect)
			hold_cnt_r <= 40'h0;
		else if (hold_cnt_r != 40'hFF_FFFF_FFFF)
			hold_cnt_r <= hold_cnt_r + 40'h1;
	end
	always_comb begin
		unique case (hold_sel_s) // R15
			HOLD_15S:  hold_expired = hold_cnt_r >= 40'(HOLD_SHORT);
			HOLD_45S:  hold_expired = hold_cnt_r >= 40'(HOLD_LONG);
			HOLD_RSVD: hold_expired = 1'b0;
			HOLD_INF:  hold_expired = 1'b0;
		endcase
	end

	// Debounce over consecutive bursts, entry and exit
	always_ff @(posedge clk) begin
		if (reset) begin
			deb_cnt_r <= 4'h0;
			detect    <= 1'b0;
		end else if (burst_done_r && cal_done) begin
			if (below == detect)
				deb_cnt_r <= 4'h0; // R8 R16
			else if (deb_cnt_r + 4'h1 >=
				(detect ? EXIT_DEB : ENTRY_DEB)) begin
				detect    <= below; // R13 R16
				deb_cnt_r <= 4'h0;
			end else
				deb_cnt_r <= deb_cnt_r + 4'h1; // R8
		end
	end
endmodule // cttd_top

// >>> sim/cttd_electrode.sv
module cttd_electrode (
	// Sequencer strobes, trip point and comparator
	input  wire logic        clk,
	input  wire logic        transfer_en,
	input  wire logic        discharge_en,
	input  wire logic [11:0] pulses,
	output logic             burst_trip_level
);
	logic [11:0] done_r;
	// Transfers since the last discharge
	always_ff @(posedge clk)
		done_r <= discharge_en ? 12'h000 : done_r + 12'($fell(transfer_en));
	// Trips early in the last transfer, low once discharged
	assign burst_trip_level = done_r + 12'(transfer_en) >= pulses;
endmodule // cttd_electrode

// >>> sim/cttd_assertions.sv
module cttd_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Watched ports
	input wire logic [1:0]  detect_threshold_sel,
	input wire logic [1:0]  ref_hold_sel,
	input wire logic        charge_en,
	input wire logic        transfer_en,
	input wire logic        discharge_en,
	input wire logic        detect,
	input wire logic        cal_done,
	input wire logic [11:0] signal_count,
	input wire logic [11:0] reference
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Phase order and calibration; an overlap would short the electrode
	a_phase_excl: assert property (!(charge_en && transfer_en))
		else $error("overlap");
	a_xfer_after: assert property ($rose(transfer_en) |-> $past(charge_en))
		else $error("order");
	a_charge_then: assert property ($fell(charge_en) |-> transfer_en)
		else $error("order");
	a_cal_stays: assert property (cal_done |=> cal_done) else $error("cal");
	a_det_cal: assert property (detect |-> cal_done) else $error("early");
	// Reference only moves between bursts
	a_ref_idle: assert property ($changed(reference) |-> discharge_en)
		else $error("ref");
	a_ref_frozen:
		assert property (detect && ref_hold_sel == 2'h3 ##1 detect |->
			$stable(reference)) else $error("ref moved");
	a_det_margin:
		assert property ($rose(detect) && detect_threshold_sel == 2'h0 |->
			$past(reference) - signal_count >= 12'h008)
			else $error("margin");
	c_cal: cover property ($rose(cal_done));
	c_det: cover property ($rose(detect));
	c_clr: cover property ($fell(detect));
	c_release: cover property (detect && $changed(reference));
endmodule // cttd_checker
bind cttd_top cttd_checker chk (.clk(clk), .reset(reset),
	.detect_threshold_sel(detect_threshold_sel),
	.ref_hold_sel(ref_hold_sel), .charge_en(charge_en),
	.transfer_en(transfer_en), .discharge_en(discharge_en),
	.detect(detect), .cal_done(cal_done),
	.signal_count(signal_count), .reference(reference));

// >>> sim/test_cttd_top.sv
module test_cttd_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cttd_pkg::*;
	// Straps, electrode setting, watched outputs
	logic        clk = 1'b0, reset = 1'b1, burst_trip_level;
	logic        charge_en, transfer_en, discharge_en, detect, cal_done;
	logic [1:0]  detect_threshold_sel = 2'h0, ref_hold_sel = HOLD_INF;
	logic [1:0]  power_mode = 2'h0;
	logic [11:0] signal_count, reference, pulses = 12'h028, r;
	int          miscompares = 0, comparisons = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	// Short counts so the run fits; low-power strap on by default
	cttd_top #(.HOLD_SHORT(64'hFA0), .SAMPLE_DIV(32'h1F4),
		.LP_SAMPLE_DIV(32'h320), .PHASE_CYC(32'h4)) dut (
		.clk(clk), .reset(reset), .power_mode(power_mode),
		.detect_threshold_sel(detect_threshold_sel),
		.ref_hold_sel(ref_hold_sel),
		.burst_trip_level(burst_trip_level),
		.charge_en(charge_en), .transfer_en(transfer_en),
		.discharge_en(discharge_en), .detect(detect),
		.cal_done(cal_done), .signal_count(signal_count),
		.reference(reference));
	cttd_electrode far (.clk(clk), .transfer_en(transfer_en),
		.discharge_en(discharge_en), .pulses(pulses),
		.burst_trip_level(burst_trip_level));
	// Hang guard
	initial begin
		repeat (95000) @(posedge clk);
		miscompares++;
		conclude();
	end
	task automatic conclude();
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [24:0] e, logic [24:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// Wait n burst ends, then let results settle
	task automatic bursts(int n);
		repeat (n) @(posedge discharge_en);
		repeat (5) @(posedge clk);
	endtask
	// Cycles between two burst starts
	task automatic gap(logic [24:0] e);
		time t;
		@(negedge discharge_en) t = $time;
		@(negedge discharge_en) chk("period", e, 25'(($time - t) / 40));
	endtask
	task automatic t_cal();
		gap(25'h1F4);
		bursts(30);
		chk("cal early", 25'h0, cal_done);
		bursts(1);
		chk("cal", 25'h1028028, {cal_done, reference, signal_count});
		gap(25'h320);
		power_mode <= PWR_NORMAL;
		gap(25'h1F4);
		power_mode <= 2'h0;
		bursts(1);
	endtask
	task automatic t_codes();
		logic [11:0] low [4] = '{12'h01E, 12'h024, 12'h022, 12'h025};
		for (int c = 0; c < 4; c++) begin
			detect_threshold_sel <= 2'(c);
			pulses <= low[c];
			bursts(3);
			chk("entry early", 25'h0, detect);
			bursts(1);
			chk("entry", 25'h1, detect);
			r = reference;
			bursts(3);
			chk("frozen", r, reference);
			pulses <= 12'h028;
			bursts(3);
			chk("exit early", 25'h1, detect);
			bursts(1);
			chk("exit", 25'h0, detect);
		end
	endtask
	// Drop smaller than the proximity threshold is absorbed, not reported
	task automatic t_below();
		detect_threshold_sel <= THR_STD_PROX;
		r = reference;
		pulses <= reference - 12'h005;
		bursts(17);
		chk("sub thr", 25'h0, detect);
		chk("absorb", 25'h1, reference < r);
	endtask
	// Long detection: frozen first, then released by the short timeout
	task automatic t_timeout();
		ref_hold_sel <= HOLD_15S;
		pulses <= reference - 12'h00A;
		bursts(4);
		chk("long entry", 25'h1, detect);
		r = reference;
		bursts(3);
		chk("held", r, reference);
		bursts(10);
		chk("released", 25'h1, reference < r);
	endtask
	initial begin
		@(posedge clk);
		#1 chk("reset", 25'h1, {detect, cal_done, charge_en, discharge_en});
		@(posedge clk) reset <= 1'b0;
		t_cal();
		t_codes();
		t_below();
		t_timeout();
		conclude();
	end
endmodule // test_cttd_top
